//--- hw/cit_defs.vh
// Shared constants for the core instruction timing model.
`ifndef CIT_DEFS_VH
`define CIT_DEFS_VH

// ****************************************************************
// Operand sizes
// ****************************************************************
`define CIT_SIZE_BYTE 2'h0
`define CIT_SIZE_WORD 2'h1
`define CIT_SIZE_LONG 2'h2

// ****************************************************************
// Source addressing modes
// ****************************************************************
`define CIT_SRC_DREG 4'h0
`define CIT_SRC_AREG 4'h1
`define CIT_SRC_IND 4'h2
`define CIT_SRC_POSTINC 4'h3
`define CIT_SRC_PREDEC 4'h4
`define CIT_SRC_D16_AN 4'h5
`define CIT_SRC_D8_AN 4'h6
`define CIT_SRC_ABS_W 4'h7
`define CIT_SRC_ABS_L 4'h8
`define CIT_SRC_D16_PC 4'h9
`define CIT_SRC_D8_PC 4'hA
`define CIT_SRC_IMM 4'hB

// ****************************************************************
// Destination addressing modes
// ****************************************************************
`define CIT_DST_REG 3'h0
`define CIT_DST_IND 3'h1
`define CIT_DST_POSTINC 3'h2
`define CIT_DST_PREDEC 3'h3
`define CIT_DST_D16 3'h4
`define CIT_DST_D8 3'h5
`define CIT_DST_ABS_SHORT_OR_LONG 3'h6

// ****************************************************************
// Base cycle figures
// ****************************************************************
`define CIT_CYC_REG_SRC 3'h1
`define CIT_CYC_IMM_TO_REG 3'h1
`define CIT_CYC_IMM_TO_MEM_BW 3'h3
`define CIT_CYC_IMM_TO_MEM_L 3'h2
`define CIT_CYC_MEM_SRC_BW 3'h3
`define CIT_CYC_MEM_SRC_L 3'h2
`define CIT_CYC_INDEX_EXTRA 3'h1

// ****************************************************************
// Local-bus access codes for split operand references
// ****************************************************************
`define CIT_ACC_NONE 2'h0
`define CIT_ACC_BYTE 2'h1
`define CIT_ACC_WORD 2'h2
`define CIT_ACC_LONG 2'h3

// ****************************************************************
// Misalignment penalties, cycles then references
// ****************************************************************
`define CIT_MIS_SHORT_RD_CYC 2'h2
`define CIT_MIS_SHORT_RD_REF 2'h1
`define CIT_MIS_SHORT_WR_CYC 2'h1
`define CIT_MIS_SHORT_WR_REF 2'h1
`define CIT_MIS_LONG_RD_CYC 2'h3
`define CIT_MIS_LONG_RD_REF 2'h2
`define CIT_MIS_LONG_WR_CYC 2'h2
`define CIT_MIS_LONG_WR_REF 2'h2

// ****************************************************************
// Store resource busy window in core cycles
// ****************************************************************
`define CIT_STORE_WINDOW 2'h2

`endif

//--- hw/cit_move_lut.v
// Base execution time lookup for byte, word and long moves.
`timescale 1ns/100ps
`include "cit_defs.vh"

module cit_move_lut (
    input wire [1:0] size,
    input wire [3:0] src_mode,
    input wire [2:0] dst_mode,
    output reg [2:0] base_cycles,
    output reg base_reads,
    output reg base_writes,
    output reg supported
);

    reg [3:0] src_norm;
    reg dst_mem;
    reg dst_idx;
    reg src_idx;
    reg is_long;

    always @* begin
        src_norm = src_mode;
        // PC-relative sources fold onto their An-relative twins.
        if (src_mode == `CIT_SRC_D16_PC) begin
            src_norm = `CIT_SRC_D16_AN;
        end else if (src_mode == `CIT_SRC_D8_PC) begin
            src_norm = `CIT_SRC_D8_AN;
        end else if (src_mode == `CIT_SRC_ABS_L) begin
            src_norm = `CIT_SRC_ABS_W;
        end
        // One destination code covers both absolute forms.
        dst_mem = (dst_mode != `CIT_DST_REG);
        dst_idx = (dst_mode == `CIT_DST_D8);
        src_idx = (src_norm == `CIT_SRC_D8_AN);
        is_long = (size == `CIT_SIZE_LONG);
        case (src_norm)
            `CIT_SRC_DREG, `CIT_SRC_AREG, `CIT_SRC_IND, `CIT_SRC_POSTINC,
            `CIT_SRC_PREDEC: begin
                supported = (dst_mode <= `CIT_DST_ABS_SHORT_OR_LONG);
            end
            `CIT_SRC_D16_AN: begin
                supported = (dst_mode <= `CIT_DST_D16);
            end
            `CIT_SRC_D8_AN, `CIT_SRC_ABS_W, `CIT_SRC_IMM: begin
                supported = (dst_mode <= `CIT_DST_PREDEC);
            end
            default: begin
                supported = 1'b0;
            end
        endcase
        if (size == 2'h3) begin
            supported = 1'b0;
        end
        base_writes = dst_mem;
        if (src_norm == `CIT_SRC_DREG || src_norm == `CIT_SRC_AREG) begin
            base_reads = 1'b0;
            base_cycles = dst_idx ? (`CIT_CYC_REG_SRC + `CIT_CYC_INDEX_EXTRA)
                                  : `CIT_CYC_REG_SRC;
        end else if (src_norm == `CIT_SRC_IMM) begin
            base_reads = 1'b0;
            if (!dst_mem) begin
                base_cycles = `CIT_CYC_IMM_TO_REG;
            end else if (is_long) begin
                base_cycles = `CIT_CYC_IMM_TO_MEM_L;
            end else begin
                base_cycles = `CIT_CYC_IMM_TO_MEM_BW;
            end
        end else begin
            base_reads = 1'b1;
            base_cycles = is_long ? `CIT_CYC_MEM_SRC_L : `CIT_CYC_MEM_SRC_BW;
            if (src_idx || dst_idx) begin
                base_cycles = base_cycles + `CIT_CYC_INDEX_EXTRA;
            end
        end
        if (!supported) begin
            base_cycles = 3'h0;
            base_reads = 1'b0;
            base_writes = 1'b0;
        end
    end

endmodule

//--- hw/cit_timing_core.v
// Cycle-level timing model of the operand execution pipeline for moves.
`timescale 1ns/100ps
`include "cit_defs.vh"

module cit_timing_core #(
    parameter CW = 8,
    parameter SW = 32
) (
    input wire core_clk,
    input wire rst_b,
    input wire issue_valid,
    input wire issue_words_ready,
    input wire [1:0] issue_size,
    input wire [3:0] issue_src_mode,
    input wire [2:0] issue_dst_mode,
    input wire [1:0] issue_src_addr_lo,
    input wire [1:0] issue_dst_addr_lo,
    input wire issue_multi_move,
    input wire [CW-1:0] issue_multi_cycles,
    input wire [3:0] issue_multi_reads,
    input wire [3:0] issue_multi_writes,
    output reg issue_ready,
    output reg exec_busy,
    output reg exec_done,
    output reg [CW-1:0] exec_cycles,
    output reg [3:0] exec_reads,
    output reg [3:0] exec_writes,
    output reg [1:0] stall_cycles,
    output reg store_window_busy,
    output reg unsupported,
    output reg [5:0] rd_split,
    output reg [1:0] rd_split_len,
    output reg [5:0] wr_split,
    output reg [1:0] wr_split_len,
    output reg [SW-1:0] retired_count,
    output reg [SW-1:0] cycle_total
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_STALL = 2'h1;
    localparam ST_EXEC = 2'h2;

    reg [1:0] state_reg;
    reg [CW-1:0] exec_left_reg;
    reg [1:0] stall_left_reg;
    reg [1:0] window_reg;
    reg cur_store_reg;
    reg cur_multi_reg;

    // ****************************************************************
    // Base time lookup
    // ****************************************************************
    wire [2:0] lut_cycles;
    wire lut_reads;
    wire lut_writes;
    wire lut_supported;

    cit_move_lut u_lut (
        .size(issue_size),
        .src_mode(issue_src_mode),
        .dst_mode(issue_dst_mode),
        .base_cycles(lut_cycles),
        .base_reads(lut_reads),
        .base_writes(lut_writes),
        .supported(lut_supported)
    );

    // ****************************************************************
    // Misalignment decode
    // ****************************************************************
    // Returns {extra cycles[1:0], extra refs[1:0]} for one operand.
    function [3:0] mis_cost;
        input [1:0] size;
        input [1:0] lo;
        input is_write;
        begin
            mis_cost = 4'h0;
            if (size == `CIT_SIZE_WORD && lo[0]) begin
                mis_cost = is_write ? {`CIT_MIS_SHORT_WR_CYC, `CIT_MIS_SHORT_WR_REF}
                                    : {`CIT_MIS_SHORT_RD_CYC, `CIT_MIS_SHORT_RD_REF};
            end else if (size == `CIT_SIZE_LONG && lo[0]) begin
                mis_cost = is_write ? {`CIT_MIS_LONG_WR_CYC, `CIT_MIS_LONG_WR_REF}
                                    : {`CIT_MIS_LONG_RD_CYC, `CIT_MIS_LONG_RD_REF};
            end else if (size == `CIT_SIZE_LONG && lo == 2'h2) begin
                mis_cost = is_write ? {`CIT_MIS_SHORT_WR_CYC, `CIT_MIS_SHORT_WR_REF}
                                    : {`CIT_MIS_SHORT_RD_CYC, `CIT_MIS_SHORT_RD_REF};
            end
        end
    endfunction

    // Returns {length[1:0], access2, access1, access0} of local-bus accesses.
    function [7:0] split_of;
        input [1:0] size;
        input [1:0] lo;
        begin
            split_of = {2'h1, `CIT_ACC_NONE, `CIT_ACC_NONE, `CIT_ACC_BYTE};
            if (size == `CIT_SIZE_WORD) begin
                if (lo[0]) begin
                    split_of = {2'h2, `CIT_ACC_NONE, `CIT_ACC_BYTE, `CIT_ACC_BYTE};
                end else begin
                    split_of = {2'h1, `CIT_ACC_NONE, `CIT_ACC_NONE, `CIT_ACC_WORD};
                end
            end else if (size == `CIT_SIZE_LONG) begin
                if (lo[0]) begin
                    split_of = {2'h3, `CIT_ACC_BYTE, `CIT_ACC_WORD, `CIT_ACC_BYTE};
                end else if (lo[1]) begin
                    split_of = {2'h2, `CIT_ACC_NONE, `CIT_ACC_WORD, `CIT_ACC_WORD};
                end else begin
                    split_of = {2'h1, `CIT_ACC_NONE, `CIT_ACC_NONE, `CIT_ACC_LONG};
                end
            end
        end
    endfunction

    // ****************************************************************
    // Totals for the offered instruction
    // ****************************************************************
    reg [3:0] rd_cost;
    reg [3:0] wr_cost;
    reg [7:0] rd_split_w;
    reg [7:0] wr_split_w;
    reg [CW-1:0] tot_cycles;
    reg [3:0] tot_reads;
    reg [3:0] tot_writes;
    reg [CW-1:0] multi_cycles;
    reg offer_store;

    always @* begin
        rd_cost = lut_reads ? mis_cost(issue_size, issue_src_addr_lo, 1'b0) : 4'h0;
        wr_cost = lut_writes ? mis_cost(issue_size, issue_dst_addr_lo, 1'b1) : 4'h0;
        rd_split_w = lut_reads ? split_of(issue_size, issue_src_addr_lo) : 8'h00;
        wr_split_w = lut_writes ? split_of(issue_size, issue_dst_addr_lo) : 8'h00;
        // Base cycles and the misalignment cycles of both operands land in one count; reads and writes are counted apart.
        tot_cycles = {{(CW-3){1'b0}}, lut_cycles}
                   + {{(CW-2){1'b0}}, rd_cost[3:2]}
                   + {{(CW-2){1'b0}}, wr_cost[3:2]};
        tot_reads = {3'h0, lut_reads} + {2'h0, rd_cost[1:0]};
        tot_writes = {3'h0, lut_writes} + {2'h0, wr_cost[1:0]};
        multi_cycles = (issue_multi_cycles == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1}
                                                         : issue_multi_cycles;
        offer_store = lut_writes;
    end

    // Opword and extensions are complete at issue, so no fetch wait follows.
    wire accept;
    assign accept = issue_valid && issue_ready && issue_words_ready;

    wire exec_last;
    assign exec_last = (state_reg == ST_EXEC) && (exec_left_reg == {{(CW-1){1'b0}}, 1'b1});

    // ****************************************************************
    // Store busy window
    // ****************************************************************
    always @(posedge core_clk) begin
        if (!rst_b) begin
            window_reg <= 2'h0;
            store_window_busy <= 1'b0;
        end else begin
            if (exec_last && cur_store_reg && !cur_multi_reg) begin
                window_reg <= `CIT_STORE_WINDOW;
                store_window_busy <= 1'b1;
            end else if (window_reg != 2'h0) begin
                window_reg <= window_reg - 2'h1;
                store_window_busy <= (window_reg != 2'h1);
            end else begin
                store_window_busy <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Issue, stall and execution sequencing
    // ****************************************************************
    always @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            exec_left_reg <= {CW{1'b0}};
            stall_left_reg <= 2'h0;
            cur_store_reg <= 1'b0;
            cur_multi_reg <= 1'b0;
            issue_ready <= 1'b1;
            exec_busy <= 1'b0;
            exec_done <= 1'b0;
            exec_cycles <= {CW{1'b0}};
            exec_reads <= 4'h0;
            exec_writes <= 4'h0;
            stall_cycles <= 2'h0;
            unsupported <= 1'b0;
            rd_split <= 6'h00;
            rd_split_len <= 2'h0;
            wr_split <= 6'h00;
            wr_split_len <= 2'h0;
        end else begin
            exec_done <= 1'b0;
            unsupported <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (accept && issue_multi_move) begin
                        // Separate resources: no window check, no stall.
                        state_reg <= ST_EXEC;
                        exec_left_reg <= multi_cycles;
                        cur_store_reg <= 1'b0;
                        cur_multi_reg <= 1'b1;
                        issue_ready <= 1'b0;
                        exec_busy <= 1'b1;
                        exec_cycles <= multi_cycles;
                        exec_reads <= issue_multi_reads;
                        exec_writes <= issue_multi_writes;
                        stall_cycles <= 2'h0;
                        rd_split <= 6'h00;
                        rd_split_len <= 2'h0;
                        wr_split <= 6'h00;
                        wr_split_len <= 2'h0;
                    end else if (accept && !lut_supported) begin
                        unsupported <= 1'b1;
                    end else if (accept) begin
                        exec_left_reg <= tot_cycles;
                        cur_store_reg <= offer_store;
                        cur_multi_reg <= 1'b0;
                        issue_ready <= 1'b0;
                        exec_busy <= 1'b1;
                        exec_cycles <= tot_cycles;
                        exec_reads <= tot_reads;
                        exec_writes <= tot_writes;
                        rd_split <= rd_split_w[5:0];
                        rd_split_len <= rd_split_w[7:6];
                        wr_split <= wr_split_w[5:0];
                        wr_split_len <= wr_split_w[7:6];
                        if (offer_store && window_reg != 2'h0) begin
                            state_reg <= ST_STALL;
                            stall_left_reg <= window_reg;
                            stall_cycles <= window_reg;
                        end else begin
                            state_reg <= ST_EXEC;
                            stall_cycles <= 2'h0;
                        end
                    end
                end
                ST_STALL: begin
                    // The stall lasts what remained of the window, never above two.
                    if (stall_left_reg == 2'h1) begin
                        state_reg <= ST_EXEC;
                    end
                    stall_left_reg <= stall_left_reg - 2'h1;
                end
                ST_EXEC: begin
                    // Zero-wait memory lets each cycle retire without hold-off.
                    exec_left_reg <= exec_left_reg - {{(CW-1){1'b0}}, 1'b1};
                    if (exec_last) begin
                        state_reg <= ST_IDLE;
                        issue_ready <= 1'b1;
                        exec_busy <= 1'b0;
                        exec_done <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    issue_ready <= 1'b1;
                    exec_busy <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Running totals
    // ****************************************************************
    always @(posedge core_clk) begin
        if (!rst_b) begin
            retired_count <= {SW{1'b0}};
            cycle_total <= {SW{1'b0}};
        end else if (exec_last) begin
            retired_count <= retired_count + {{(SW-1){1'b0}}, 1'b1};
            cycle_total <= cycle_total + {{(SW-CW){1'b0}}, exec_cycles}
                         + {{(SW-2){1'b0}}, stall_cycles};
        end
    end

endmodule

//--- test/cit_timing_core_assertions.sv
// Concurrent checks on the move timing model ports.
`timescale 1ns/100ps
module cit_timing_chk #(
    parameter CW = 8
) (
    input wire core_clk,
    input wire rst_b,
    input wire issue_valid,
    input wire issue_words_ready,
    input wire issue_multi_move,
    input wire issue_ready,
    input wire exec_busy,
    input wire exec_done,
    input wire [CW-1:0] exec_cycles,
    input wire [1:0] stall_cycles,
    input wire store_window_busy,
    input wire unsupported,
    input wire [5:0] rd_split,
    input wire [1:0] rd_split_len
);
    // ****************************************************************
    // Busy cycle counter
    // ****************************************************************
    reg [9:0] busy_cnt_reg;
    always @(posedge core_clk) begin
        if (!rst_b) begin
            busy_cnt_reg <= 10'h000;
        end else begin
            busy_cnt_reg <= exec_busy ? busy_cnt_reg + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_done_time: assert property (exec_done |->
        busy_cnt_reg == exec_cycles + stall_cycles)
        else $error("done does not follow stall plus cycles");
    a_done_pulse: assert property (exec_done |=> !exec_done)
        else $error("done longer than one cycle");
    a_taken_fast: assert property (issue_valid && issue_words_ready && issue_ready |=>
        !issue_ready || unsupported) else $error("loaded request not taken");
    a_window_two: assert property ($rose(store_window_busy) |->
        store_window_busy ##1 store_window_busy ##1 !store_window_busy)
        else $error("store window not two cycles");
    a_stall_max: assert property (exec_busy |-> stall_cycles != 2'h3)
        else $error("stall above two");
    a_idle_no_stall: assert property ($rose(exec_busy) && !$past(store_window_busy) |->
        stall_cycles == 2'h0) else $error("stall without window");
    a_multi_free: assert property ($rose(exec_busy) && $past(issue_multi_move) |->
        stall_cycles == 2'h0) else $error("multi move stalled");
    a_long_split: assert property ($rose(exec_busy) && rd_split_len == 2'h3 |->
        rd_split == 6'h19) else $error("three part split wrong");
    a_refuse_idle: assert property (unsupported |-> issue_ready && !exec_busy)
        else $error("refusal changed state");
    c_stall_two: cover property ($rose(exec_busy) && stall_cycles == 2'h2);
    c_refused: cover property (unsupported);
    c_multi: cover property ($rose(exec_busy) && $past(issue_multi_move));
    c_long_split: cover property (rd_split_len == 2'h3);
endmodule

bind cit_timing_core cit_timing_chk #(.CW(CW)) cit_timing_chk_i (
    .core_clk(core_clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .issue_words_ready(issue_words_ready), .issue_multi_move(issue_multi_move),
    .issue_ready(issue_ready), .exec_busy(exec_busy), .exec_done(exec_done),
    .exec_cycles(exec_cycles), .stall_cycles(stall_cycles),
    .store_window_busy(store_window_busy), .unsupported(unsupported),
    .rd_split(rd_split), .rd_split_len(rd_split_len)
);

//--- test/cit_mem_model.sv
// Zero-wait local-bus memory that counts the accesses of each move that is not a multi move.
`timescale 1ns/100ps
module cit_mem_model (
    input wire core_clk,
    input wire rst_b,
    input wire exec_busy,
    input wire multi_flag,
    input wire [1:0] rd_split_len,
    input wire [1:0] wr_split_len,
    output reg [15:0] acc_count
);
    reg busy_q_reg;
    // Every access is answered in the cycle it is issued, so no move waits.
    always @(posedge core_clk) begin
        busy_q_reg <= rst_b & exec_busy;
        if (!rst_b) begin
            acc_count <= 16'h0000;
        end else if (exec_busy && !busy_q_reg && !multi_flag) begin
            acc_count <= acc_count + rd_split_len + wr_split_len;
        end
    end
endmodule

//--- test/tb_cit_timing_core.sv
// Self-checking bench for the move timing model.
`timescale 1ns/100ps
module tb_cit_timing_core;
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg issue_valid = 1'b0;
    reg issue_words_ready = 1'b0;
    reg [1:0] issue_size = 2'h0;
    reg [3:0] issue_src_mode = 4'h0;
    reg [2:0] issue_dst_mode = 3'h0;
    reg [1:0] issue_src_addr_lo = 2'h0;
    reg [1:0] issue_dst_addr_lo = 2'h0;
    reg issue_multi_move = 1'b0;
    reg [7:0] issue_multi_cycles = 8'h00;
    reg [3:0] issue_multi_reads = 4'h0;
    reg [3:0] issue_multi_writes = 4'h0;
    wire issue_ready, exec_busy, exec_done, store_window_busy, unsupported;
    wire [7:0] exec_cycles;
    wire [3:0] exec_reads, exec_writes;
    wire [1:0] stall_cycles, rd_split_len, wr_split_len;
    wire [5:0] rd_split, wr_split;
    wire [31:0] retired_count, cycle_total;
    wire [15:0] acc_count;
    integer bad_count = 0;
    integer total_checks = 0;
    integer retired = 0;
    integer cyc_sum = 0;
    integer acc_sum = 0;
    time store_t = 0;
    always #20 core_clk = ~core_clk;
    cit_timing_core #(.CW(8), .SW(32)) cit_timing_core_i (
        .core_clk(core_clk), .rst_b(rst_b), .issue_valid(issue_valid),
        .issue_words_ready(issue_words_ready), .issue_size(issue_size),
        .issue_src_mode(issue_src_mode), .issue_dst_mode(issue_dst_mode),
        .issue_src_addr_lo(issue_src_addr_lo), .issue_dst_addr_lo(issue_dst_addr_lo),
        .issue_multi_move(issue_multi_move), .issue_multi_cycles(issue_multi_cycles),
        .issue_multi_reads(issue_multi_reads), .issue_multi_writes(issue_multi_writes),
        .issue_ready(issue_ready), .exec_busy(exec_busy), .exec_done(exec_done),
        .exec_cycles(exec_cycles), .exec_reads(exec_reads), .exec_writes(exec_writes),
        .stall_cycles(stall_cycles), .store_window_busy(store_window_busy),
        .unsupported(unsupported), .rd_split(rd_split), .rd_split_len(rd_split_len),
        .wr_split(wr_split), .wr_split_len(wr_split_len),
        .retired_count(retired_count), .cycle_total(cycle_total));
    cit_mem_model cit_mem_model_i (.core_clk(core_clk), .rst_b(rst_b), .exec_busy(exec_busy),
        .multi_flag(issue_multi_move), .rd_split_len(rd_split_len),
        .wr_split_len(wr_split_len), .acc_count(acc_count));
    task check(input [63:0] seen, input [63:0] exp, input [8*10-1:0] what);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // Returns the access count and access codes of one operand.
    function [7:0] split_of(input [1:0] sz, input [1:0] lo);
        begin
            if (sz == 2'h1 && lo[0]) split_of = 8'h85;
            else if (sz == 2'h2 && lo[0]) split_of = 8'hD9;
            else if (sz == 2'h2 && lo == 2'h2) split_of = 8'h8A;
            else split_of = {6'h10, sz + 2'h1};
        end
    endfunction
    function integer mis(input [1:0] sz, input [1:0] lo);
        mis = ((sz == 2'h1 && lo[0]) || (sz == 2'h2 && lo == 2'h2)) ? 1
            : (sz == 2'h2 && lo[0]) ? 2 : 0;
    endfunction
    task run_one(input [1:0] sz, input [3:0] src, input [2:0] dst, input [1:0] slo,
        input [1:0] dlo, input mm, input integer gap);
        integer sup, c, r, w, k, st, n;
        reg [7:0] rs, ws;
        begin
            repeat (gap) begin
                @(posedge core_clk);
                #1;
            end
            sup = sz < 3 && src < 12 && dst < 7
                && (src < 5 || dst < 4 || (dst == 4 && (src == 5 || src == 9)));
            if (src < 2) c = (dst == 5) ? 2 : 1;
            else if (src == 11) c = (dst == 0) ? 1 : (sz == 2 ? 2 : 3);
            else c = (sz == 2 ? 2 : 3)
                + (src == 6 || src == 10 || dst == 5);
            r = (src > 1 && src < 11);
            w = (dst != 0);
            n = ($time - store_t) / 40;
            st = (n < 2 && !mm && w > 0) ? 2 - n : 0;
            k = r * mis(sz, slo);
            c = c + k + (k > 0);
            r = r + k;
            k = w * mis(sz, dlo);
            c = c + k;
            w = w + k;
            issue_multi_cycles = $urandom % 8;
            issue_multi_reads = $urandom % 16;
            issue_multi_writes = $urandom % 16;
            if (mm) begin
                sup = 1;
                c = (issue_multi_cycles == 0) ? 1 : issue_multi_cycles;
                r = issue_multi_reads;
                w = issue_multi_writes;
            end
            issue_size = sz;
            issue_src_mode = src;
            issue_dst_mode = dst;
            issue_src_addr_lo = slo;
            issue_dst_addr_lo = dlo;
            issue_multi_move = mm;
            issue_valid = 1'b1;
            issue_words_ready = 1'b1;
            @(posedge core_clk);
            #1;
            issue_valid = 1'b0;
            issue_words_ready = $urandom % 2;
            if (!sup) begin
                check({unsupported, issue_ready, exec_busy}, 3'h6, "refuse");
            end else begin
                check({exec_busy, issue_ready}, 2'h2, "busy");
                check(stall_cycles, st, "stall");
                check(exec_cycles, c, "cycles");
                check({exec_reads, exec_writes}, r * 16 + w, "refs");
                rs = r > 0 ? split_of(sz, slo) : 8'h00;
                ws = w > 0 ? split_of(sz, dlo) : 8'h00;
                if (!mm) begin
                    check({rd_split_len, rd_split}, rs, "rd split");
                    check({wr_split_len, wr_split}, ws, "wr split");
                    acc_sum = acc_sum + rs[7:6] + ws[7:6];
                end
                n = 1;
                while (exec_done !== 1'b1 && n < 64) begin
                    @(posedge core_clk);
                    #1;
                    n = n + 1;
                end
                check(n - 1, st + c, "done time");
                retired = retired + 1;
                cyc_sum = cyc_sum + st + c;
                if (!mm && dst != 0) store_t = $time;
            end
        end
    endtask
    initial begin : main
        integer sz, src, dst;
        reg [31:0] rl;
        rl = $urandom(18);
        repeat (20) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        issue_valid = 1'b1;
        repeat (3) begin
            @(posedge core_clk);
            #1;
        end
        check({issue_ready, exec_busy}, 2'h2, "held off");
        $display("test reset done");
        for (sz = 0; sz < 4; sz = sz + 1) begin
            for (src = 0; src < 16; src = src + 1) begin
                for (dst = 0; dst < 8; dst = dst + 1) begin
                    rl = $urandom;
                    run_one(sz[1:0], src[3:0], dst[2:0], rl[1:0], rl[3:2], 1'b0, rl[5:4] % 3);
                end
            end
            $display("test size %0d done", sz);
        end
        for (sz = 0; sz < 24; sz = sz + 1) begin
            run_one(2'h2, 4'h0, 3'h1, 2'h0, 2'h0, sz[0], sz % 3);
        end
        $display("test multi done");
        repeat (3) @(posedge core_clk);
        #1;
        check(retired_count, retired, "retired");
        check(cycle_total, cyc_sum, "cyc total");
        check(acc_count, acc_sum, "accesses");
        close_out;
    end
    // About 2000 cycles are expected; allow twenty-five times that before giving up.
    initial begin
        #2000000;
        bad_count = bad_count + 1;
        close_out;
    end
endmodule
